// [design/psl_pkg.sv]
package psl_pkg;
  // time base: one tick per millisecond
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned TICK_US    = 1000;
  localparam int unsigned TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          TW         = 15;

  localparam int unsigned DEB_MS     = 20;
  localparam int unsigned MIN_MS     = 100;
  localparam int unsigned MAX_MS     = 2000;
  localparam int unsigned RST_MS     = 3000;
  localparam int unsigned REARM_MS   = 3000;
  localparam int unsigned KEYGEN_MS  = 30000;
  localparam int unsigned SEARCH_MS  = 30000;
  localparam int unsigned QON_MS     = 100;
  localparam int unsigned QOFF_MS    = 150;
  localparam int unsigned SON_MS     = 500;
  localparam int unsigned SOFF_MS    = 500;
  localparam int unsigned GAP_MS     = 500;

  localparam logic [TW-1:0] T_DEB    = TW'(DEB_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_MIN    = TW'(MIN_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_MAX    = TW'(MAX_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_RST    = TW'(RST_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_REARM  = TW'(REARM_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_KEYGEN = TW'(KEYGEN_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_SEARCH = TW'(SEARCH_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_QON    = TW'(QON_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_QOFF   = TW'(QOFF_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_SON    = TW'(SON_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_SOFF   = TW'(SOFF_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_GAP    = TW'(GAP_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] T_SAT    = 15'h7fff;

  localparam logic [2:0]  NP_JOIN    = 3'h1;
  localparam logic [2:0]  NP_TEST    = 3'h3;
  localparam logic [2:0]  NP_RESET   = 3'h4;
  localparam logic [13:0] FACTORY_BAUD = 14'h2580;
  localparam logic [1:0]  KEY_NODE   = 2'h1;
  localparam logic [1:0]  KEY_ADMIN  = 2'h2;

  typedef enum logic [3:0] {
    PAT_NONE   = 4'h0,
    PAT_ADMIN  = 4'h1,
    PAT_NODE   = 4'h2,
    PAT_XFER   = 4'h3,
    PAT_XDONE  = 4'h4,
    PAT_CANCEL = 4'h5,
    PAT_FAIL   = 4'h6,
    PAT_ACK    = 4'h7,
    PAT_RESET  = 4'h8,
    PAT_TEST1  = 4'h9,
    PAT_TEST2  = 4'ha,
    PAT_TEST3  = 4'hb
  } psl_pat_type;
endpackage : psl_pkg

// [design/psl_blink.sv]
`timescale 1ns/100ps
module psl_blink (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  // pattern control
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] quick_i,
  input  wire logic [2:0] reps_i,
  // result
  output logic            led_o,
  output logic            done_o
);
  import psl_pkg::*;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_SON  = 3'h1,
    PH_SOFF = 3'h2,
    PH_QON  = 3'h3,
    PH_QOFF = 3'h4,
    PH_GAP  = 3'h5,
    PH_DONE = 3'h6
  } psl_ph_type;

  typedef struct packed {
    psl_ph_type    ph;
    logic [TW-1:0] cnt;
    logic [1:0]    qleft;
    logic [2:0]    grp;
    logic          led;
    logic          done;
  } psl_blk_type;

  psl_blk_type q, n;
  logic        gend;

  always_comb begin
    n      = q;
    gend   = 1'b0;
    n.done = 1'b0;
    if (tick_i && q.cnt != T_SAT) n.cnt = q.cnt + 15'h1;
    if (!run_i) begin
      n.ph  = PH_IDLE;
      n.cnt = '0;
      n.grp = '0;
      n.led = 1'b0;
    end else begin
      unique case (q.ph)
        PH_IDLE: begin
          n.cnt   = '0;
          n.led   = 1'b1;
          n.qleft = quick_i;
          n.ph    = slow_i ? PH_SON : PH_QON;
        end
        PH_SON: if (q.cnt >= T_SON) begin
          n.ph  = PH_SOFF;
          n.cnt = '0;
          n.led = 1'b0;
        end
        PH_SOFF: if (q.cnt >= T_SOFF) begin
          n.cnt = '0;
          if (quick_i != 2'h0) begin
            n.ph  = PH_QON;
            n.led = 1'b1;
          end else begin
            gend = 1'b1;
          end
        end
        PH_QON: if (q.cnt >= T_QON) begin
          n.ph    = PH_QOFF;
          n.cnt   = '0;
          n.led   = 1'b0;
          n.qleft = q.qleft - 2'h1;
        end
        PH_QOFF: if (q.cnt >= T_QOFF) begin
          n.cnt = '0;
          if (q.qleft != 2'h0) begin
            n.ph  = PH_QON;
            n.led = 1'b1;
          end else begin
            n.ph = PH_GAP;
          end
        end
        PH_GAP: if (q.cnt >= T_GAP) gend = 1'b1;
        PH_DONE: n.led = 1'b0;
        default: n.ph = PH_IDLE;
      endcase
      // group finished: stop after reps groups, zero repeats forever
      if (gend) begin
        n.grp = q.grp + 3'h1;
        if (reps_i != 3'h0 && n.grp == reps_i) begin
          n.ph   = PH_DONE;
          n.done = 1'b1;
        end else begin
          n.ph = PH_IDLE;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) q <= '{ph: PH_IDLE, default: '0};
    else q <= n;
  end

  assign led_o  = q.led;
  assign done_o = q.done;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  AST_QON_LEN: assert property (
    q.ph == PH_QOFF && $past(q.ph) == PH_QON |-> $past(q.cnt) >= T_QON)
    else $error("quick blink ended early");
  AST_REPS_DONE: assert property (
    done_o |-> $past(reps_i) != 3'h0 && $past(q.grp) + 3'h1 == $past(reps_i))
    else $error("pattern finished at wrong group count");
  AST_STOP: assert property (!run_i |=> !led_o)
    else $error("led lit while pattern stopped");
endmodule : psl_blink

// [design/psl_status_led.sv]
`timescale 1ns/100ps
module psl_status_led #(
  parameter int unsigned TICK_CYCLES = psl_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // pushbutton pin
  input  wire logic        pushbutton_in,
  // pairing status from the controller
  input  wire logic        pair_busy_i,
  input  wire logic        admin_search_i,
  input  wire logic        node_search_i,
  input  wire logic        key_xfer_i,
  input  wire logic        key_xfer_done_i,
  input  wire logic        pair_fail_i,
  input  wire logic [1:0]  key_state_i,
  input  wire logic        pkt_activity_i,
  // triggers
  output logic             join_start_o,
  output logic             join_cancel_o,
  output logic             keygen_start_o,
  output logic             key_test_o,
  output logic             factory_restore_o,
  output logic             restart_o,
  output logic [13:0]      factory_baud_o,
  // indicator
  output logic             status_led_out
);
  import psl_pkg::*;

  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_HIGH  = 3'h1,
    S_LOW   = 3'h2,
    S_BAD   = 3'h3,
    S_LHOLD = 3'h4,
    S_RHOLD = 3'h5
  } psl_prs_type;

  typedef struct packed {
    logic [2:0]    sync;
    logic [TW-1:0] deb;
    logic          btn;
    logic [TW-1:0] div;
    logic          tick;
    psl_prs_type   st;
    logic [2:0]    npulse;
    logic [TW-1:0] tcnt;
    logic [TW-1:0] scnt;
    psl_pat_type   one;
    psl_pat_type   sel;
    psl_pat_type   psel;
    logic          led;
    logic          join_start;
    logic          join_cancel;
    logic          keygen;
    logic          key_test;
    logic          restore;
    logic          restart;
    logic [13:0]   baud;
  } psl_main_type;

  psl_main_type q, n;
  logic         hold;
  logic         blk_run;
  logic [5:0]   blk_cfg;
  logic         blk_led;
  logic         blk_done;

  // {slow first, quick count, groups (0 = endless)}
  function automatic logic [5:0] pat_cfg(input psl_pat_type p);
    unique case (p)
      PAT_ADMIN:  pat_cfg = {1'b0, 2'h2, 3'h0};
      PAT_NODE:   pat_cfg = {1'b0, 2'h1, 3'h0};
      PAT_XFER:   pat_cfg = {1'b0, 2'h1, 3'h0};
      PAT_XDONE:  pat_cfg = {1'b1, 2'h0, 3'h6};
      PAT_CANCEL: pat_cfg = {1'b0, 2'h2, 3'h1};
      PAT_FAIL:   pat_cfg = {1'b1, 2'h0, 3'h3};
      PAT_ACK:    pat_cfg = {1'b1, 2'h2, 3'h0};
      PAT_RESET:  pat_cfg = {1'b0, 2'h3, 3'h0};
      PAT_TEST1:  pat_cfg = {1'b0, 2'h1, 3'h3};
      PAT_TEST2:  pat_cfg = {1'b0, 2'h2, 3'h3};
      PAT_TEST3:  pat_cfg = {1'b0, 2'h3, 3'h3};
      default:    pat_cfg = 6'h00;
    endcase
  endfunction : pat_cfg

  assign hold    = (q.st == S_LHOLD) || (q.st == S_RHOLD);
  assign blk_cfg = pat_cfg(q.sel);
  // one idle cycle whenever the selection changes restarts the pattern
  assign blk_run = (q.sel != PAT_NONE) && (q.sel == q.psel);

  always_comb begin
    n             = q;
    n.tick        = 1'b0;
    n.join_start  = 1'b0;
    n.join_cancel = 1'b0;
    n.keygen      = 1'b0;
    n.key_test    = 1'b0;
    n.restore     = 1'b0;
    n.restart     = q.restore;
    n.sync        = {q.sync[1:0], pushbutton_in};
    if (q.div == TICK_LAST) begin
      n.div  = '0;
      n.tick = 1'b1;
    end else begin
      n.div = q.div + 15'h1;
    end
    // accept a level only after stable for the debounce time
    if (q.sync[1] == q.sync[2] && q.sync[2] != q.btn) begin
      if (q.tick) n.deb = q.deb + 15'h1;
      if (q.deb >= T_DEB) begin
        n.btn = q.sync[2];
        n.deb = '0;
      end
    end else begin
      n.deb = '0;
    end
    if (q.tick && q.tcnt != T_SAT) n.tcnt = q.tcnt + 15'h1;
    if (blk_done && q.one == q.sel) n.one = PAT_NONE;

    unique case (q.st)
      S_IDLE: begin
        n.npulse = 3'h0;
        n.tcnt   = '0;
        if (q.btn) n.st = S_HIGH;
      end
      S_HIGH: begin
        if (q.btn) begin
          if (q.npulse == 3'h0 && q.tcnt >= T_KEYGEN) begin
            n.keygen = 1'b1;
            n.st     = S_LHOLD;
          end else if (q.npulse == NP_RESET && q.tcnt > T_RST) begin
            n.st = S_RHOLD;
          end
        end else if (q.tcnt < T_MIN || q.tcnt > T_MAX || q.npulse == NP_RESET) begin
          n.st   = S_BAD;
          n.tcnt = '0;
        end else begin
          n.npulse = q.npulse + 3'h1;
          n.st     = S_LOW;
          n.tcnt   = '0;
        end
      end
      S_LOW: begin
        if (q.btn) begin
          n.tcnt = '0;
          n.st   = (q.tcnt < T_MIN) ? S_BAD : S_HIGH;
        end else if (q.tcnt > T_MAX) begin
          n.st = S_IDLE;
          if (q.npulse == NP_JOIN) begin
            if (pair_busy_i) begin
              n.join_cancel = 1'b1;
              n.one         = PAT_CANCEL;
            end else begin
              n.join_start = 1'b1;
            end
          end else if (q.npulse == NP_TEST) begin
            n.key_test = 1'b1;
            if (key_state_i == KEY_ADMIN) n.one = PAT_TEST3;
            else if (key_state_i == KEY_NODE) n.one = PAT_TEST2;
            else n.one = PAT_TEST1;
          end
        end
      end
      S_BAD: begin
        if (q.btn) n.tcnt = '0;
        else if (q.tcnt >= T_REARM) n.st = S_IDLE;
      end
      S_LHOLD: if (!q.btn) n.st = S_IDLE;
      S_RHOLD: if (!q.btn) begin
        n.restore = 1'b1;
        n.baud    = FACTORY_BAUD;
        n.st      = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase

    if (pair_fail_i) n.one = PAT_FAIL;
    if (key_xfer_done_i) n.one = PAT_XDONE;

    if (!(admin_search_i || node_search_i)) n.scnt = '0;
    else if (q.tick && q.scnt != T_SAT) n.scnt = q.scnt + 15'h1;

    n.psel = q.sel;
    if (q.st == S_RHOLD) n.sel = PAT_RESET;
    else if (q.st == S_LHOLD) n.sel = PAT_ACK;
    else if (q.one != PAT_NONE) n.sel = q.one;
    else if (key_xfer_i) n.sel = PAT_XFER;
    else if (admin_search_i && q.scnt < T_SEARCH) n.sel = PAT_ADMIN;
    else if (node_search_i && q.scnt < T_SEARCH) n.sel = PAT_NODE;
    else n.sel = PAT_NONE;

    if (hold) n.led = blk_led;
    else if (q.btn) n.led = 1'b1;
    else if (q.sel != PAT_NONE) n.led = blk_led;
    else n.led = pkt_activity_i;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{st: S_IDLE, one: PAT_NONE, sel: PAT_NONE, psel: PAT_NONE, default: '0};
    end else begin
      q <= n;
    end
  end

  psl_blink u_blink (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (q.tick),
    .run_i    (blk_run),
    .slow_i   (blk_cfg[5]),
    .quick_i  (blk_cfg[4:3]),
    .reps_i   (blk_cfg[2:0]),
    .led_o    (blk_led),
    .done_o   (blk_done)
  );

  assign status_led_out    = q.led;
  assign join_start_o      = q.join_start;
  assign join_cancel_o     = q.join_cancel;
  assign keygen_start_o    = q.keygen;
  assign key_test_o        = q.key_test;
  assign factory_restore_o = q.restore;
  assign restart_o         = q.restart;
  assign factory_baud_o    = q.baud;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_join_end;
    q.st == S_LOW && !q.btn && q.tcnt > T_MAX && q.npulse == NP_JOIN;
  endsequence
  sequence s_rst_hold;
    q.st == S_HIGH && q.btn && q.npulse == NP_RESET && q.tcnt > T_RST;
  endsequence
  sequence s_release;
    q.st == S_RHOLD && !q.btn;
  endsequence

  AST_JOIN_START: assert property (
    s_join_end ##0 !pair_busy_i |=> join_start_o && !join_cancel_o)
    else $error("join not started");
  AST_JOIN_CANCEL: assert property (
    s_join_end ##0 pair_busy_i && !pair_fail_i && !key_xfer_done_i
      |=> join_cancel_o && q.one == PAT_CANCEL)
    else $error("cancel not signalled");
  AST_KEYGEN: assert property (
    $rose(keygen_start_o) |-> $past(q.tcnt) >= T_KEYGEN && $past(q.npulse) == 3'h0)
    else $error("key generation without thirty second hold");
  AST_ACK: assert property (
    q.st == S_LHOLD ##1 q.st == S_LHOLD |-> q.sel == PAT_ACK)
    else $error("no long hold acknowledgement");
  AST_KEYTEST: assert property (
    key_test_o |-> $past(q.npulse) == NP_TEST)
    else $error("key test without three pulses");
  AST_RST_SEQ: assert property (s_rst_hold |=> q.st == S_RHOLD)
    else $error("reset sequence not recognised");
  AST_RST_BLINK: assert property (
    q.st == S_RHOLD ##1 q.st == S_RHOLD |-> q.sel == PAT_RESET)
    else $error("no groups of three during reset hold");
  AST_RESTORE: assert property (
    s_release |=> factory_restore_o && factory_baud_o == FACTORY_BAUD ##1 restart_o)
    else $error("restore and restart not issued");
  AST_SHORT_LOW: assert property (
    q.st == S_LOW && q.btn && q.tcnt < T_MIN |=> q.st == S_BAD)
    else $error("short low interval accepted");
  AST_REARM: assert property (q.st == S_BAD && q.btn |=> q.st == S_BAD)
    else $error("rearmed while button high");
  AST_SEARCH: assert property (
    q.sel == PAT_ADMIN |-> $past(q.scnt) < T_SEARCH)
    else $error("admin search shown past thirty seconds");
  AST_BTN_LED: assert property (q.btn && !hold |=> status_led_out)
    else $error("led dark while button high");
  AST_IDLE_LED: assert property (
    !q.btn && !hold && q.sel == PAT_NONE |=> status_led_out == $past(pkt_activity_i))
    else $error("led does not follow packet activity");
  AST_DEBOUNCE: assert property (
    q.btn != $past(q.btn) |-> $past(q.sync[2]) == q.btn && $past(q.deb) >= T_DEB)
    else $error("button level taken without debounce");
  AST_FAIL: assert property (
    pair_fail_i && !key_xfer_done_i |=> q.one == PAT_FAIL)
    else $error("failure pattern not queued");
endmodule : psl_status_led

// [tb/psl_pb_model.sv]
`timescale 1ns/100ps
module psl_pb_model #(
  parameter int unsigned TICK = 1
) (
  // clock
  input  wire logic mclk_i,
  // lamp side
  input  wire logic led_i,
  // button side
  output logic      pb_o
);
  int unsigned n_rises;
  int unsigned low_run;
  logic        led_q;

  initial begin
    pb_o    = 1'b0;
    n_rises = 0;
    low_run = 0;
    led_q   = 1'b0;
  end

  // lamp observer: blink count and length of the current dark stretch
  always @(posedge mclk_i) begin
    if (led_i === 1'b1 && led_q !== 1'b1) n_rises <= n_rises + 1;
    led_q   <= led_i;
    low_run <= (led_i === 1'b0) ? low_run + 1 : 0;
  end

  task automatic ticks(input int unsigned n);
    repeat (n * TICK) @(posedge mclk_i);
    #2;
  endtask : ticks

  // released button reads low through the pull-down
  task automatic set_pb(input logic v);
    pb_o = v;
  endtask : set_pb

  task automatic pulses(input int unsigned n, input int unsigned hi, input int unsigned lo);
    for (int unsigned i = 0; i < n; i++) begin
      pb_o = 1'b1;
      ticks(hi);
      pb_o = 1'b0;
      ticks(lo);
    end
  endtask : pulses
endmodule : psl_pb_model

// [tb/psl_status_led_tb.sv]
`timescale 1ns/100ps
module psl_status_led_tb;
  import psl_pkg::*;
  localparam int unsigned TK = 1;
  typedef struct packed {
    int unsigned n;
    logic        busy;
    logic [1:0]  kst;
    int unsigned st;
    int unsigned cn;
    int unsigned kt;
    int unsigned rises;
  } psl_row_type;

  logic        mclk_i;
  logic        arst_n_i;
  logic        pb;
  logic        pair_busy;
  logic        pkt;
  logic [1:0]  kst;
  logic [4:0]  stat;
  logic        join_start;
  logic        join_cancel;
  logic        keygen;
  logic        ktest;
  logic        restore;
  logic        restart;
  logic [13:0] baud;
  logic        led;
  int unsigned n_errors;
  int unsigned n_compared;
  int unsigned cnt [6];
  int unsigned base;
  psl_row_type rows [6] = '{
    '{1, 1'b0, 2'h0, 1, 0, 0, 1},
    '{1, 1'b1, 2'h0, 0, 1, 0, 3},
    '{3, 1'b0, 2'h0, 0, 0, 1, 6},
    '{3, 1'b0, 2'h1, 0, 0, 1, 9},
    '{3, 1'b0, 2'h2, 0, 0, 1, 12},
    '{2, 1'b0, 2'h0, 0, 0, 0, 2}};

  psl_status_led #(
    .TICK_CYCLES (TK)
  ) u_psl_status_led (
    .mclk_i            (mclk_i),
    .arst_n_i          (arst_n_i),
    .pushbutton_in     (pb),
    .pair_busy_i       (pair_busy),
    .admin_search_i    (stat[3]),
    .node_search_i     (stat[4]),
    .key_xfer_i        (stat[2]),
    .key_xfer_done_i   (stat[1]),
    .pair_fail_i       (stat[0]),
    .key_state_i       (kst),
    .pkt_activity_i    (pkt),
    .join_start_o      (join_start),
    .join_cancel_o     (join_cancel),
    .keygen_start_o    (keygen),
    .key_test_o        (ktest),
    .factory_restore_o (restore),
    .restart_o         (restart),
    .factory_baud_o    (baud),
    .status_led_out    (led)
  );

  psl_pb_model #(
    .TICK (TK)
  ) u_psl_pb_model (
    .mclk_i (mclk_i),
    .led_i  (led),
    .pb_o   (pb)
  );

  always #20 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    if (join_start === 1'b1) cnt[0]++;
    if (join_cancel === 1'b1) cnt[1]++;
    if (ktest === 1'b1) cnt[2]++;
    if (keygen === 1'b1) cnt[3]++;
    if (restore === 1'b1) cnt[4]++;
    if (restart === 1'b1) cnt[5]++;
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic clr();
    cnt  = '{default: 0};
    base = u_psl_pb_model.n_rises;
  endtask : clr

  // let a pattern start, then wait until the lamp stays dark for 800 ticks
  task automatic quiet();
    int unsigned k;
    k = 0;
    repeat (8) @(posedge mclk_i);
    while (u_psl_pb_model.low_run < 800 * TK && k < 20000 * TK) begin
      @(posedge mclk_i);
      k++;
    end
    #2;
    if (k >= 20000 * TK) begin
      chk(1'b0, "lamp never settled");
      report_and_stop();
    end
  endtask : quiet

  // one status input: pulse when len is 0, else level for len ticks
  task automatic pat(input int unsigned w, input int unsigned len, input int unsigned lo,
                     input int unsigned hi);
    int unsigned r;
    clr();
    stat[w] = 1'b1;
    if (len == 0) u_psl_pb_model.ticks(1);
    else u_psl_pb_model.ticks(len);
    stat[w] = 1'b0;
    quiet();
    r = u_psl_pb_model.n_rises - base;
    chk(r >= lo && r <= hi, "status pattern blink count");
    $display("test status pattern %0d done", w);
  endtask : pat

  initial begin
    mclk_i = 1'b0;
    arst_n_i = 1'b0;
    pair_busy = 1'b0;
    pkt = 1'b0;
    kst = 2'h0;
    stat = 5'h00;
    n_errors = 0;
    n_compared = 0;
    cnt = '{default: 0};
    repeat (12) @(posedge mclk_i);
    #2;
    chk(led === 1'b0 && baud === 14'h0000 && restore === 1'b0, "outputs in reset");
    $display("test reset done");
    arst_n_i = 1'b1;
    u_psl_pb_model.ticks(100);
    foreach (rows[i]) begin
      pair_busy = rows[i].busy;
      kst = rows[i].kst;
      clr();
      u_psl_pb_model.pulses(rows[i].n, 200, 200);
      u_psl_pb_model.ticks(1900);
      quiet();
      chk(cnt[0] == rows[i].st, "join start count");
      chk(cnt[1] == rows[i].cn, "join cancel count");
      chk(cnt[2] == rows[i].kt, "key test count");
      chk(u_psl_pb_model.n_rises - base == rows[i].rises, "blinks");
      chk(cnt[3] + cnt[4] + cnt[5] == 0, "unexpected trigger");
      pair_busy = 1'b0;
      $display("test row %0d done", i);
    end
    // long hold: lit, then key generation and repeating acknowledgement
    clr();
    u_psl_pb_model.set_pb(1'b1);
    u_psl_pb_model.ticks(15000);
    chk(led === 1'b1, "lamp lit while holding");
    u_psl_pb_model.ticks(15500);
    chk(cnt[3] == 1, "key generation trigger");
    base = u_psl_pb_model.n_rises;
    u_psl_pb_model.ticks(2500);
    chk(u_psl_pb_model.n_rises - base >= 3, "hold acknowledgement");
    u_psl_pb_model.set_pb(1'b0);
    u_psl_pb_model.ticks(200);
    chk(cnt[0] + cnt[2] + cnt[4] == 0 && cnt[3] == 1, "after hold");
    $display("test long hold done");
    // short high in the sequence: ignored, then low 3 s rearms
    clr();
    u_psl_pb_model.pulses(3, 200, 200);
    u_psl_pb_model.pulses(1, 60, 200);
    u_psl_pb_model.set_pb(1'b1);
    u_psl_pb_model.ticks(3500);
    u_psl_pb_model.set_pb(1'b0);
    u_psl_pb_model.ticks(3200);
    // short low interval: the lone press must not start a join
    u_psl_pb_model.pulses(1, 200, 60);
    u_psl_pb_model.pulses(1, 200, 3200);
    chk(cnt[0] == 0, "short low ignored");
    chk(cnt[4] == 0 && baud === 14'h0000, "bad sequence ignored");
    chk(u_psl_pb_model.n_rises - base == 7, "no reset blinks");
    $display("test bad reset done");
    // valid factory reset sequence
    clr();
    u_psl_pb_model.pulses(4, 200, 200);
    u_psl_pb_model.set_pb(1'b1);
    u_psl_pb_model.ticks(3300);
    chk(cnt[4] == 0, "no restore while held");
    base = u_psl_pb_model.n_rises;
    u_psl_pb_model.ticks(2000);
    chk(u_psl_pb_model.n_rises - base >= 3, "reset blink groups");
    u_psl_pb_model.set_pb(1'b0);
    u_psl_pb_model.ticks(100);
    chk(cnt[4] == 1 && cnt[5] == 1, "restore and restart");
    chk(baud === 14'h2580, "restored serial rate 9600");
    $display("test factory reset done");
    quiet();
    pat(0, 0, 3, 3);
    pat(1, 0, 6, 6);
    pat(2, 1600, 3, 5);
    pat(3, 1000, 2, 4);
    pat(4, 1000, 2, 3);
    pkt = 1'b1;
    u_psl_pb_model.ticks(10);
    chk(led === 1'b1, "lamp on with packet");
    pkt = 1'b0;
    u_psl_pb_model.ticks(10);
    chk(led === 1'b0, "lamp off idle");
    $display("test packet activity done");
    report_and_stop();
  end
endmodule : psl_status_led_tb
